// ---- rtl/psram_host_defines.svh ----
// timing counts, widths and pattern constants for the pseudo-static ram host
`ifndef PSRAM_HOST_DEFINES_SVH
`define PSRAM_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define ADDR_W 22
`define DATA_W 16
`define TIMER_W 14
`define PROG_CNT_W 3

// least times, printed figures
`define PG_LOW_HOLD_US 50
`define SEL_HIGH_HOLD_US 300
`define STROBE_HOLD_NS 10
`define PD_GATE_LOW_NS 65
`define SEL_HIGH_PULSE_NS 12
`define READ_CYCLE_NS 70
`define WRITE_CYCLE_NS 65

// least times rounded up to whole clock cycles
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PG_LOW_HOLD_CYC `CEIL_CYC(`PG_LOW_HOLD_US * 1000)
`define SEL_HIGH_HOLD_CYC `CEIL_CYC(`SEL_HIGH_HOLD_US * 1000)
`define STROBE_HOLD_CYC `CEIL_CYC(`STROBE_HOLD_NS)
`define PD_GATE_LOW_CYC `CEIL_CYC(`PD_GATE_LOW_NS)
`define SEL_HIGH_PULSE_CYC `CEIL_CYC(`SEL_HIGH_PULSE_NS)
`define READ_CYCLE_CYC `CEIL_CYC(`READ_CYCLE_NS)
`define WRITE_CYCLE_CYC `CEIL_CYC(`WRITE_CYCLE_NS)
// extra read cycles covering the three-stage pin filter plus the hold register
`define DQ_SYNC_LAT_CYC 4

// power-down programming sequence
`define PD_ONES_CYCLES 5
`define PD_KEY_CYCLE 6

`endif

// ---- rtl/psram_host_pkg.sv ----
// types shared by the pseudo-static ram host
`include "psram_host_defines.svh"

package psram_host_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef logic [`TIMER_W-1:0] count_t;
    typedef logic [`PROG_CNT_W-1:0] prog_cnt_t;

    typedef enum logic [7:0] {
        ST_PWR_LOW  = 8'h01,
        ST_PWR_HOLD = 8'h02,
        ST_IDLE     = 8'h04,
        ST_RD       = 8'h08,
        ST_WR       = 8'h10,
        ST_END      = 8'h20,
        ST_GAP      = 8'h40,
        ST_PD_LOW   = 8'h80
    } state_e;
endpackage

// ---- rtl/psram_wait_timer.sv ----
// down counter that times every wait of the host sequencer
module psram_wait_timer (
    input wire logic clk_i,
    input wire logic rst_sync_b_i,
    input wire logic load_i,
    input wire psram_host_pkg::count_t load_val_i,
    output logic done_o
);
    import psram_host_pkg::*;

    count_t count_q;
    count_t count_d;

    // reload on request, otherwise count down to zero and stop
    always_comb begin
        count_d = count_q;
        if (load_i) begin
            count_d = load_val_i;
        end else if (count_q != '0) begin
            count_d = count_q - count_t'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_sync_b_i) begin
        if (!rst_sync_b_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // done comes from the register alone, so a load made on done cannot loop back into it
    assign done_o = (count_q == '0);
endmodule

// ---- rtl/psram_host_ctrl.sv ----
// host sequencer driving the pins of an asynchronous pseudo-static ram
//
// Overview of operation
// - gate low at least 50 us after supply
// - select high 300 us after gate rises
// - strobes steady 10 ns after select rises
// - write strobe hold avoids stray writes
// - read with select low needs a byte lane
// - read strobe may stay low in select-controlled write
// - select may stay low, strobes control access
// - reads need gate high, write strobe high
// - power-down entry and exit resets device
// - programming cycles one to five: address all ones
// - sixth programming cycle presents the address key
// - power-down gate low at least 65 ns
`include "psram_host_defines.svh"

module psram_host_ctrl #(
    parameter int unsigned SEL_HIGH_HOLD_CYC = `SEL_HIGH_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // user side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire psram_host_pkg::addr_t req_addr_i,
    input wire psram_host_pkg::data_t req_wdata_i,
    input wire logic [1:0] req_byte_en_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output psram_host_pkg::data_t rsp_rdata_o,
    input wire logic strobe_only_i,
    input wire logic pd_reset_req_i,
    input wire logic pd_prog_req_i,
    input wire psram_host_pkg::addr_t pd_key_i,
    output logic pd_done_o,
    output logic init_done_o,
    // memory pins
    output psram_host_pkg::addr_t addr_o,
    input wire psram_host_pkg::data_t dq_i,
    output psram_host_pkg::data_t dq_o,
    output logic dq_oe_o,
    output logic chip_select_n_o,
    output logic power_gate_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic low_byte_select_n_o,
    output logic high_byte_select_n_o
);
    import psram_host_pkg::*;

    // reset release through two flip-flops
    logic rst_meta_q;
    logic rst_sync_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_b <= rst_meta_q;
        end
    end

    // data pins pass three flip-flops; a bit counts once stages two and three agree
    data_t dq_s1_q;
    data_t dq_s2_q;
    data_t dq_s3_q;
    data_t dq_f_q;
    data_t dq_f_d;

    always_comb begin
        dq_f_d = dq_f_q;
        for (int i = 0; i < `DATA_W; i++) begin
            if (dq_s2_q[i] == dq_s3_q[i]) begin
                dq_f_d[i] = dq_s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            dq_s3_q <= '0;
            dq_f_q <= '0;
        end else begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            dq_f_q <= dq_f_d;
        end
    end

    // decoding of the two byte-lane selects for an access
    function automatic logic [1:0] lanes_n(input logic is_read, input logic [1:0] en);
        logic [1:0] res;
        res = ~en;
        if (is_read && (en == 2'b00)) begin
            res = 2'b00; // a read with no lane chosen takes both
        end
        return res;
    endfunction

    // sequencer state
    state_e state_q;
    state_e state_d;
    logic rd_q;
    logic rd_d;
    logic prog_q;
    logic prog_d;
    prog_cnt_t prog_cnt_q;
    prog_cnt_t prog_cnt_d;
    addr_t key_q;
    addr_t key_d;
    logic hold_sel_q;
    logic hold_sel_d;
    logic init_q;
    logic init_d;
    logic first_q;
    logic first_d;

    // pin registers
    addr_t addr_q;
    addr_t addr_d;
    data_t dq_q;
    data_t dq_d;
    logic dq_oe_q;
    logic dq_oe_d;
    logic cs_n_q;
    logic cs_n_d;
    logic pg_q;
    logic pg_d;
    logic oe_n_q;
    logic oe_n_d;
    logic we_n_q;
    logic we_n_d;
    logic [1:0] bs_n_q;
    logic [1:0] bs_n_d;

    // answer registers
    logic rsp_valid_q;
    logic rsp_valid_d;
    data_t rsp_rdata_q;
    data_t rsp_rdata_d;
    logic pd_done_q;
    logic pd_done_d;

    // shared wait timer
    logic tmr_load;
    count_t tmr_val;
    logic tmr_done;

    psram_wait_timer u_timer (
        .clk_i(clk_i),
        .rst_sync_b_i(rst_sync_b),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .done_o(tmr_done)
    );

    // sequencer next state and pin values
    always_comb begin
        state_d = state_q;
        rd_d = rd_q;
        prog_d = prog_q;
        prog_cnt_d = prog_cnt_q;
        key_d = key_q;
        hold_sel_d = hold_sel_q;
        init_d = init_q;
        addr_d = addr_q;
        dq_d = dq_q;
        dq_oe_d = dq_oe_q;
        cs_n_d = cs_n_q;
        pg_d = pg_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        bs_n_d = bs_n_q;
        rsp_valid_d = 1'b0;
        rsp_rdata_d = rsp_rdata_q;
        pd_done_d = 1'b0;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_q)
            ST_PWR_LOW: begin
                if (first_q) begin
                    tmr_load = 1'b1; // gate low hold starts at reset release
                    tmr_val = count_t'(`PG_LOW_HOLD_CYC - 1);
                end else if (tmr_done) begin
                    pg_d = 1'b1; // gate rises only after its low hold
                    tmr_load = 1'b1;
                    tmr_val = count_t'(SEL_HIGH_HOLD_CYC - 1);
                    state_d = ST_PWR_HOLD;
                end
            end
            ST_PWR_HOLD: begin
                if (tmr_done) begin
                    init_d = 1'b1; // select kept high for the whole hold
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                cs_n_d = !strobe_only_i; // select parked low in strobe-only mode
                if (pd_reset_req_i) begin
                    pg_d = 1'b0; // power-down entry used as device reset
                    cs_n_d = 1'b1;
                    init_d = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = count_t'(`PD_GATE_LOW_CYC - 1);
                    state_d = ST_PD_LOW;
                end else if (pd_prog_req_i) begin
                    prog_d = 1'b1;
                    prog_cnt_d = prog_cnt_t'(1);
                    key_d = pd_key_i;
                    hold_sel_d = 1'b0;
                    rd_d = 1'b1;
                    addr_d = '1; // first programming cycle, all address ones
                    cs_n_d = 1'b0;
                    oe_n_d = 1'b0;
                    we_n_d = 1'b1;
                    bs_n_d = 2'b00;
                    tmr_load = 1'b1;
                    tmr_val = count_t'(`READ_CYCLE_CYC + `DQ_SYNC_LAT_CYC - 1);
                    state_d = ST_RD;
                end else if (req_valid_i) begin
                    hold_sel_d = strobe_only_i;
                    rd_d = !req_write_i;
                    addr_d = req_addr_i; // address set in the same cycle as the strobe falling edges and, unless select is parked low, the select falling edge
                    cs_n_d = 1'b0;
                    bs_n_d = lanes_n(!req_write_i, req_byte_en_i);
                    tmr_load = 1'b1;
                    if (req_write_i) begin
                        dq_d = req_wdata_i;
                        dq_oe_d = 1'b1;
                        oe_n_d = 1'b1; // read strobe high, low-strobe write unused
                        we_n_d = 1'b0;
                        tmr_val = count_t'(`WRITE_CYCLE_CYC - 1);
                        state_d = ST_WR;
                    end else begin
                        oe_n_d = 1'b0;
                        we_n_d = 1'b1; // read with write strobe high, gate high
                        tmr_val = count_t'(`READ_CYCLE_CYC + `DQ_SYNC_LAT_CYC - 1);
                        state_d = ST_RD;
                    end
                end
            end
            ST_RD, ST_WR: begin
                if (tmr_done) begin
                    if (state_q == ST_RD) begin
                        rsp_rdata_d = dq_f_q;
                    end
                    tmr_load = 1'b1;
                    tmr_val = count_t'(`STROBE_HOLD_CYC - 1);
                    if (hold_sel_q) begin
                        oe_n_d = 1'b1; // strobes alone close the access
                        we_n_d = 1'b1;
                    end else begin
                        cs_n_d = 1'b1; // strobes left as they are
                    end
                    state_d = ST_END;
                end
            end
            ST_END: begin
                if (tmr_done) begin
                    oe_n_d = 1'b1; // write strobe released after its hold when the select closed the access
                    we_n_d = 1'b1;
                    dq_oe_d = 1'b0;
                    bs_n_d = 2'b11;
                    tmr_load = 1'b1;
                    tmr_val = count_t'(`SEL_HIGH_PULSE_CYC - 1);
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                if (tmr_done) begin
                    if (prog_q && (prog_cnt_q != prog_cnt_t'(`PD_KEY_CYCLE))) begin
                        prog_cnt_d = prog_cnt_q + prog_cnt_t'(1);
                        if (prog_cnt_q == prog_cnt_t'(`PD_ONES_CYCLES)) begin
                            addr_d = key_q; // sixth cycle carries the key
                        end else begin
                            addr_d = '1; // cycles two to five stay all ones
                        end
                        cs_n_d = 1'b0;
                        oe_n_d = 1'b0;
                        bs_n_d = 2'b00;
                        tmr_load = 1'b1;
                        tmr_val = count_t'(`READ_CYCLE_CYC + `DQ_SYNC_LAT_CYC - 1);
                        state_d = ST_RD;
                    end else begin
                        if (prog_q) begin
                            pd_done_d = 1'b1; // done after the select-high pulse
                        end else if (rd_q) begin
                            rsp_valid_d = 1'b1;
                        end
                        prog_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_PD_LOW: begin
                if (tmr_done) begin
                    pg_d = 1'b1; // gate held low its least time
                    tmr_load = 1'b1;
                    tmr_val = count_t'(SEL_HIGH_HOLD_CYC - 1);
                    state_d = ST_PWR_HOLD;
                end
            end
            default: begin
                state_d = ST_PWR_LOW;
            end
        endcase
    end

    // sequencer and pin registers; power-up starts with the gate low
    always_ff @(posedge clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_q <= ST_PWR_LOW;
            rd_q <= 1'b0;
            prog_q <= 1'b0;
            prog_cnt_q <= '0;
            key_q <= '0;
            hold_sel_q <= 1'b0;
            init_q <= 1'b0;
            addr_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            cs_n_q <= 1'b1;
            pg_q <= 1'b0;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            bs_n_q <= 2'b11;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= '0;
            pd_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rd_q <= rd_d;
            prog_q <= prog_d;
            prog_cnt_q <= prog_cnt_d;
            key_q <= key_d;
            hold_sel_q <= hold_sel_d;
            init_q <= init_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            cs_n_q <= cs_n_d;
            pg_q <= pg_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            bs_n_q <= bs_n_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_rdata_q <= rsp_rdata_d;
            pd_done_q <= pd_done_d;
        end
    end

    // marks the first cycle after reset release, when the gate low hold is loaded
    always_comb begin
        first_d = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            first_q <= 1'b1;
        end else begin
            first_q <= first_d;
        end
    end

    // outputs
    assign req_ready_o = (state_q == ST_IDLE) && !pd_reset_req_i && !pd_prog_req_i;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_rdata_o = rsp_rdata_q;
    assign pd_done_o = pd_done_q;
    assign init_done_o = init_q;
    assign addr_o = addr_q;
    assign dq_o = dq_q;
    assign dq_oe_o = dq_oe_q;
    assign chip_select_n_o = cs_n_q;
    assign power_gate_o = pg_q;
    assign read_strobe_n_o = oe_n_q;
    assign write_strobe_n_o = we_n_q;
    assign low_byte_select_n_o = bs_n_q[0];
    assign high_byte_select_n_o = bs_n_q[1];
endmodule

// ---- verif/psram_host_monitor.sv ----
// concurrent checks on the pins and user side of the host sequencer
module psram_host_monitor #(
    parameter int unsigned SEL_HIGH_HOLD_CYC = 15000
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic pd_done_o,
    input wire logic init_done_o,
    input wire logic dq_oe_o,
    input wire logic chip_select_n_o,
    input wire logic power_gate_o,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic low_byte_select_n_o,
    input wire logic high_byte_select_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [15:0] low_cnt_q, low_cnt_d, up_cnt_q, up_cnt_d;

    // gate-low length and time since gate rise, both saturating
    always_comb begin
        low_cnt_d = power_gate_o ? 16'h0 : low_cnt_q + {15'h0, low_cnt_q != 16'hffff};
        up_cnt_d = !power_gate_o ? 16'h0 : up_cnt_q + {15'h0, up_cnt_q != 16'hffff};
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_q <= 16'h0;
            up_cnt_q <= 16'h0;
        end else begin
            low_cnt_q <= low_cnt_d;
            up_cnt_q <= up_cnt_d;
        end
    end

    gate_low_len_a: assert property ($rose(power_gate_o) |-> low_cnt_q >= 16'h4)
        else $error("power gate low too briefly");
    sel_high_wait_a: assert property ($fell(chip_select_n_o) |-> up_cnt_q >= SEL_HIGH_HOLD_CYC)
        else $error("select fell too soon after gate rise");
    idle_before_init_a: assert property (!init_done_o |-> chip_select_n_o && read_strobe_n_o
        && write_strobe_n_o)
        else $error("pins active before init done");
    strobe_hold_a: assert property ($rose(chip_select_n_o) |->
        $stable(read_strobe_n_o) && $stable(write_strobe_n_o))
        else $error("strobe moved as select rose");
    read_lane_a: assert property (!chip_select_n_o && !read_strobe_n_o |->
        !(low_byte_select_n_o && high_byte_select_n_o))
        else $error("read with no byte lane");
    read_mode_a: assert property (!chip_select_n_o && !read_strobe_n_o |->
        write_strobe_n_o && power_gate_o)
        else $error("read without gate high and write strobe high");
    write_drive_a: assert property (!write_strobe_n_o |-> dq_oe_o && read_strobe_n_o)
        else $error("write strobe low without data driven");
    read_answer_a: assert property (req_valid_i && req_ready_o && !req_write_i |->
        ##[9:13] rsp_valid_o)
        else $error("read answer missing");
    prog_end_a: assert property (pd_done_o |-> chip_select_n_o && $past(chip_select_n_o))
        else $error("programming done without select-high gap");

    cover property ($rose(power_gate_o));
    cover property (rsp_valid_o);
    cover property (pd_done_o);
    cover property ($fell(write_strobe_n_o) && !chip_select_n_o);
endmodule

bind psram_host_ctrl psram_host_monitor #(.SEL_HIGH_HOLD_CYC(SEL_HIGH_HOLD_CYC)) u_mon (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .pd_done_o(pd_done_o),
    .init_done_o(init_done_o), .dq_oe_o(dq_oe_o), .chip_select_n_o(chip_select_n_o),
    .power_gate_o(power_gate_o), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o), .low_byte_select_n_o(low_byte_select_n_o),
    .high_byte_select_n_o(high_byte_select_n_o));

// ---- verif/psram_device_model.sv ----
// behavioural pseudo-static ram answering the host pins
module psram_device_model #(
    parameter int RC_NS = 70
) (
    input wire psram_host_pkg::addr_t addr_i,
    input wire psram_host_pkg::data_t dq_i,
    output psram_host_pkg::data_t dq_o,
    input wire logic chip_select_n_i,
    input wire logic power_gate_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic low_byte_select_n_i,
    input wire logic high_byte_select_n_i,
    input wire logic slow_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import psram_host_pkg::*;
    data_t mem [addr_t];
    addr_t wa, key_q;
    data_t wd, v;
    logic [1:0] ln;
    logic standby = 1'b1;
    int ones = 0, prog_cnt = 0, pd_cnt = 0;
    realtime t_strobe = 0, t_gate = 0;

    // write address from the later falling edge, data and lanes just after
    always @(negedge chip_select_n_i or negedge write_strobe_n_i) begin
        #1;
        wa = addr_i; // taken once the pins of this edge have settled
        #4;
        wd = dq_i;
        ln = ~{high_byte_select_n_i, low_byte_select_n_i};
    end
    // commit on first rising edge; read strobe and parked select ignored
    always @(posedge chip_select_n_i or posedge write_strobe_n_i) begin
        if (!(chip_select_n_i && write_strobe_n_i)) begin
            v = mem.exists(wa) ? mem[wa] : '0;
            if (ln[0]) v[7:0] = wd[7:0];
            if (ln[1]) v[15:8] = wd[15:8];
            mem[wa] = v;
        end
    end
    // read data after access delay, a moving pattern when released
    always @(chip_select_n_i or read_strobe_n_i or write_strobe_n_i or addr_i or power_gate_i) begin
        if (!chip_select_n_i && !read_strobe_n_i && write_strobe_n_i && power_gate_i)
            dq_o <= #(slow_i ? 50 : 5) (mem.exists(addr_i) ? mem[addr_i] : '0);
        else
            dq_o <= #1 ~dq_o;
    end
    // standby delayed to one read cycle after select rises when a strobe moves too soon
    always @(read_strobe_n_i or write_strobe_n_i) t_strobe = $realtime;
    always @(negedge chip_select_n_i or negedge read_strobe_n_i or negedge write_strobe_n_i)
        standby = 1'b0;
    always @(posedge chip_select_n_i) begin
        #10;
        if (t_strobe >= $realtime - 10) #(RC_NS - 10);
        if (chip_select_n_i) standby = 1'b1;
    end
    // power-down entry and exit resets the array
    always @(negedge power_gate_i) t_gate = $realtime;
    always @(posedge power_gate_i) begin
        if ($realtime - t_gate >= 65) pd_cnt++;
        mem.delete();
    end
    // five all-ones cycles then the key; counted as the key cycle's select falls
    always @(negedge chip_select_n_i) begin
        #1;
        if (&addr_i) ones++;
        else begin
            if (ones == 5) begin
                key_q = addr_i;
                prog_cnt++;
            end
            ones = 0;
        end
    end
endmodule

// ---- verif/tb_psram_power_and_access_sequencing.sv ----
// self-checking bench for the pseudo-static ram host sequencer
module tb_psram_power_and_access_sequencing;
    timeunit 1ns;
    timeprecision 100ps;
    import psram_host_pkg::*;
    localparam int SEL = 20;
    logic clk_i = 0, rst_b_i = 0, req_valid_i = 0, req_write_i = 0, strobe_only_i = 0, slow = 0;
    logic pd_reset_req_i = 0, pd_prog_req_i = 0, w;
    addr_t req_addr_i = '0, pd_key_i = '0, addr_o, key;
    data_t req_wdata_i = '0, rsp_rdata_o, dq_o, dq_i, mdl_dq;
    logic [1:0] req_byte_en_i = '0, be;
    logic req_ready_o, rsp_valid_o, pd_done_o, init_done_o, dq_oe_o;
    logic cs_n, pg, oe_n, we_n, lb_n, ub_n;
    int errors = 0, n_checks = 0, t;
    data_t ref_mem [addr_t];
    addr_t aset [8];

    always #10 clk_i = ~clk_i;
    // shared data wire: host when enabled, else the memory
    assign dq_i = dq_oe_o ? dq_o : mdl_dq;

    psram_host_ctrl #(.SEL_HIGH_HOLD_CYC(SEL)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_byte_en_i(req_byte_en_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .strobe_only_i(strobe_only_i),
        .pd_reset_req_i(pd_reset_req_i), .pd_prog_req_i(pd_prog_req_i), .pd_key_i(pd_key_i),
        .pd_done_o(pd_done_o), .init_done_o(init_done_o), .addr_o(addr_o), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .chip_select_n_o(cs_n), .power_gate_o(pg),
        .read_strobe_n_o(oe_n), .write_strobe_n_o(we_n), .low_byte_select_n_o(lb_n),
        .high_byte_select_n_o(ub_n));
    psram_device_model mdl (.addr_i(addr_o), .dq_i(dq_i), .dq_o(mdl_dq), .chip_select_n_i(cs_n),
        .power_gate_i(pg), .read_strobe_n_i(oe_n), .write_strobe_n_i(we_n),
        .low_byte_select_n_i(lb_n), .high_byte_select_n_i(ub_n), .slow_i(slow));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_min(input int got, input int lo);
        n_checks++;
        if (got < lo) begin
            errors++;
            $display("mismatch at %0t: got %h expected at least %h", $time, got, lo);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step;
        @(posedge clk_i);
        #2;
    endtask
    // one access; the reference memory predicts read data by lane
    task automatic access(input logic wr, input addr_t a, input data_t d, input logic [1:0] b,
        input logic so);
        int n;
        data_t m, e;
        req_valid_i = 1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        req_byte_en_i = b;
        strobe_only_i = so;
        while (!req_ready_o) step;
        step;
        req_valid_i = 0;
        step;
        m = {{8{b[1] | ~|b}}, {8{b[0] | ~|b}}};
        e = ref_mem.exists(a) ? ref_mem[a] : '0;
        if (wr) ref_mem[a] = (e & ~m) | (d & m);
        else begin
            n = 0;
            while (!rsp_valid_o && n < 40) begin
                step;
                n++;
            end
            chk_val(32'(rsp_valid_o), 32'h1);
            chk_val(32'(rsp_rdata_o & m), 32'(e & m));
        end
    endtask

    // hang guard
    initial begin
        #1000000;
        errors++;
        print_verdict;
    end

    initial begin
        void'($urandom(48054));
        repeat (12) @(posedge clk_i);
        #2 rst_b_i = 1;
        t = 0;
        while (!pg && t < 3000) begin
            step;
            t++;
        end
        chk_min(t, 2500);
        t = 0;
        while (!init_done_o && t < 100) begin
            step;
            t++;
        end
        chk_min(t, SEL);
        // preload, then a random mix in both select modes and speeds
        foreach (aset[i]) begin
            aset[i] = addr_t'($urandom) & 22'h3ffffe;
            access(1, aset[i], data_t'($urandom), 2'b11, 0);
        end
        repeat (60) begin
            slow = 1'($urandom % 2);
            w = 1'($urandom % 2);
            be = w ? 2'(1 + $urandom % 3) : 2'($urandom % 4);
            access(w, aset[$urandom % 8], data_t'($urandom), be, 1'($urandom % 2));
        end
        access(0, aset[0], '0, 2'b11, 0);
        chk_val(32'(mdl.standby), 32'h1);
        // power-down entry and exit as a reset
        t = mdl.pd_cnt;
        pd_reset_req_i = 1;
        repeat (5) if (init_done_o) step;
        pd_reset_req_i = 0;
        repeat (200) if (!init_done_o) step;
        chk_val(32'(mdl.pd_cnt), 32'(t + 1));
        ref_mem.delete();
        access(1, aset[1], 16'h5aa5, 2'b11, 0);
        access(0, aset[1], '0, 2'b01, 0);
        // programming with a random key that is never all ones
        key = addr_t'($urandom) & 22'h3ffffe;
        pd_key_i = key;
        pd_prog_req_i = 1;
        repeat (20) if (cs_n) step;
        pd_prog_req_i = 0;
        repeat (100) if (!pd_done_o) step;
        chk_val(32'(pd_done_o), 32'h1);
        chk_val(32'(mdl.prog_cnt), 32'h1);
        chk_val(32'(mdl.key_q), 32'(key));
        access(0, aset[1], '0, 2'b10, 0);
        print_verdict;
    end
endmodule
